// File: hdl/wrs_pkg.sv
// Constants, types and helpers shared by the reset supervisor modules.
package wrs_pkg;
   localparam int CNT_W     = 25;
   localparam int WD_EXP_00 = 19;
   localparam int WD_EXP_01 = 21;
   localparam int WD_EXP_10 = 23;
   localparam int WD_EXP_11 = 24;

   localparam logic [14:0] OPT_ADDR   = 15'h7fff;
   localparam logic [7:0]  OPT_RESET  = 8'hff;
   localparam int          OPT_WD_DIS = 1;
   localparam int          OPT_SEL_LO = 2;
   localparam int          OPT_PL_DIS = 4;

   localparam logic [11:0] OFF_RELOAD = 12'h000;
   localparam logic [11:0] OFF_OPT    = 12'h004;
   localparam logic [11:0] OFF_STAT   = 12'h008;
   localparam logic [11:0] OFF_CNT    = 12'h00c;
   localparam int          STAT_EXT   = 0;
   localparam int          STAT_PL    = 1;
   localparam int          STAT_WD    = 2;
   localparam logic [2:0]  STAT_RESET = 3'h0;

   localparam int MCLK_PS      = 5000;
   localparam int PL_REL_NS    = 2000;
   localparam int PL_REL_CYC   = (PL_REL_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
   localparam int PL_TMR_W     = $clog2(PL_REL_CYC + 1);
   localparam int RST_HOLD_CYC = 8;
   localparam int RST_HOLD_W   = $clog2(RST_HOLD_CYC + 1);
   localparam logic [2:0] SYNC_RESET = 3'h4;

   typedef enum logic [1:0] {
      PL_OK   = 2'b00,
      PL_LOW  = 2'b01,
      PL_WAIT = 2'b11
   } wrs_pl_t;

   typedef enum logic {
      LD_WAIT = 1'b0,
      LD_DONE = 1'b1
   } wrs_ld_t;

   // Watchdog interval in clock cycles for an option code.
   function automatic logic [CNT_W-1:0] wrs_limit(input logic [1:0] sel, input int e0,
                                                  input int e1, input int e2, input int e3);
      int e;
      unique case (sel)
         2'b00: e = e0;
         2'b01: e = e1;
         2'b10: e = e2;
         2'b11: e = e3;
      endcase
      return CNT_W'(1) << e;
   endfunction
endpackage

// File: hdl/wrs_wd_if.sv
// Control and status signals between the supervisor top and its watchdog counter.
`timescale 1ns/1ps
`default_nettype none
interface wrs_wd_if import wrs_pkg::*; ();
   logic             enable;
   logic [1:0]       sel;
   logic             reload;
   logic             hold;
   logic             bite;
   logic [CNT_W-1:0] count;
   modport ctl (output enable, output sel, output reload, output hold,
                input bite, input count);
   modport wd  (input enable, input sel, input reload, input hold,
                output bite, output count);
endinterface
`default_nettype wire

// File: hdl/wrs_wdog.sv
// Watchdog counter running on the system clock.
`timescale 1ns/1ps
`default_nettype none
module wrs_wdog import wrs_pkg::*; #(
   parameter int E0 = WD_EXP_00,
   parameter int E1 = WD_EXP_01,
   parameter int E2 = WD_EXP_10,
   parameter int E3 = WD_EXP_11
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   wrs_wd_if.wd     w
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             bite;
   } wrs_wdst_t;

   wrs_wdst_t        st;
   wrs_wdst_t        next_st;
   logic [CNT_W-1:0] lim;

   assign lim     = wrs_limit(w.sel, E0, E1, E2, E3);
   assign w.bite  = st.bite;
   assign w.count = st.count;

   always_comb begin
      next_st      = st;
      next_st.bite = 1'b0;
      // Any reload, disable or system reset restarts the interval from zero.
      if (!w.enable || w.reload || w.hold) begin
         next_st.count = '0;
      end else if (st.count == lim - CNT_W'(1)) begin
         next_st.count = '0;
         next_st.bite  = 1'b1;
      end else begin
         next_st.count = st.count + CNT_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   wd_bite_a: assert property (@(posedge mclk) disable iff (reset || !ce)
      st.bite |-> $past(st.count) == lim - CNT_W'(1) && $past(w.enable))
      else $error("watchdog expired at the wrong count");
   wd_off_a: assert property (@(posedge mclk) disable iff (reset || !ce)
      !w.enable |=> st.count == '0 && !st.bite)
      else $error("disabled watchdog kept counting");
endmodule
`default_nettype wire

// File: hdl/wrs_rstgen.sv
// Pin synchronisers and reset stretcher producing the system reset.
`timescale 1ns/1ps
`default_nettype none
module wrs_rstgen import wrs_pkg::*; (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic ce,
   input  wire logic ext_rst_n,
   input  wire logic vcc_below_low,
   input  wire logic vcc_above_high,
   input  wire logic rst_req,
   output logic      ext_act,
   output logic      below,
   output logic      above,
   output logic      sys_rst
);
   typedef struct packed {
      logic [2:0]            s1;
      logic [2:0]            s2;
      logic [RST_HOLD_W-1:0] hold;
      logic                  sys_rst;
   } wrs_rgst_t;

   wrs_rgst_t st;
   wrs_rgst_t next_st;
   logic      src;

   assign ext_act = ~st.s2[2];
   assign below   = st.s2[1];
   assign above   = st.s2[0];
   assign sys_rst = st.sys_rst;
   assign src     = ext_act | rst_req;

   always_comb begin
      next_st    = st;
      next_st.s1 = {ext_rst_n, vcc_below_low, vcc_above_high};
      next_st.s2 = st.s1;
      // Release only after the hold count, so a bouncing source cannot chop the reset.
      if (src) begin
         next_st.hold    = RST_HOLD_W'(RST_HOLD_CYC);
         next_st.sys_rst = 1'b1;
      end else if (st.hold != '0) begin
         next_st.hold    = st.hold - RST_HOLD_W'(1);
         next_st.sys_rst = 1'b1;
      end else begin
         next_st.sys_rst = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= '{s1: SYNC_RESET, s2: SYNC_RESET, hold: RST_HOLD_W'(RST_HOLD_CYC),
                 sys_rst: 1'b1};
      end else if (ce) begin
         st <= next_st;
      end
   end

   sequence src_drop;
      src ##1 !src;
   endsequence

   rst_src_a: assert property (@(posedge mclk) disable iff (reset || !ce)
      src |=> sys_rst)
      else $error("reset source did not assert the system reset");
   rst_hold_a: assert property (@(posedge mclk) disable iff (reset || !ce)
      src_drop |-> sys_rst [*8])
      else $error("system reset released before the hold time");
endmodule
`default_nettype wire

// File: hdl/wrs_top.sv
// Reset supervisor: reset sources, watchdog, option byte load and APB registers.
//
// Function
// - Any of three sources drives system reset.
// - Power-low resets below low, releases later.
// - Option bit four low enables power-low.
// - Watchdog counts system clock, resets on expiry.
// - Any write to reload register reloads watchdog.
// - Option bit one low enables the watchdog.
// - Option bits three, two pick interval.
// - Unprogrammed option bits read as one.
// - Options are read from flash location 7fff.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module wrs_top import wrs_pkg::*; #(
   parameter int WD_E0 = WD_EXP_00,
   parameter int WD_E1 = WD_EXP_01,
   parameter int WD_E2 = WD_EXP_10,
   parameter int WD_E3 = WD_EXP_11
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_rst_n,
   input  wire logic        vcc_below_low,
   input  wire logic        vcc_above_high,
   output logic             flash_rd,
   output logic      [14:0] flash_addr,
   input  wire logic        flash_ack,
   input  wire logic [7:0]  flash_data,
   output logic             sys_rst
);
   typedef struct packed {
      wrs_pl_t               pl;
      logic [PL_TMR_W-1:0]   pl_tmr;
      wrs_ld_t               ld;
      logic [7:0]            opt;
      logic                  flash_rd;
      logic [2:0]            cause;
      logic                  reload;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
   } wrs_top_t;

   localparam wrs_top_t TOP_RESET = '{
      pl: PL_OK, pl_tmr: '0, ld: LD_WAIT, opt: OPT_RESET, flash_rd: 1'b1,
      cause: STAT_RESET, reload: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: '0};

   wrs_top_t   st;
   wrs_top_t   next_st;
   wrs_wd_if   wd ();
   logic       ext_act;
   logic       below;
   logic       above;
   logic       pl_en;
   logic       pl_rst;
   logic       apb_acc;
   logic [2:0] clr;
   logic [2:0] set;

   assign pl_en      = ~st.opt[OPT_PL_DIS];
   assign pl_rst     = st.pl != PL_OK;
   assign apb_acc    = psel & penable;
   assign prdata     = st.prdata;
   assign pready     = st.pready;
   assign pslverr    = st.pslverr;
   assign flash_rd   = st.flash_rd;
   assign flash_addr = OPT_ADDR;

   assign wd.enable = ~st.opt[OPT_WD_DIS];
   assign wd.sel    = st.opt[OPT_SEL_LO +: 2];
   assign wd.reload = st.reload;
   assign wd.hold   = sys_rst;

   wrs_wdog #(
      .E0 (WD_E0),
      .E1 (WD_E1),
      .E2 (WD_E2),
      .E3 (WD_E3)
   ) u_wdog (
      .mclk  (mclk),
      .reset (reset),
      .ce    (ce),
      .w     (wd.wd)
   );

   wrs_rstgen u_rstgen (
      .mclk           (mclk),
      .reset          (reset),
      .ce             (ce),
      .ext_rst_n      (ext_rst_n),
      .vcc_below_low  (vcc_below_low),
      .vcc_above_high (vcc_above_high),
      .rst_req        (pl_rst | wd.bite),
      .ext_act        (ext_act),
      .below          (below),
      .above          (above),
      .sys_rst        (sys_rst)
   );

   always_comb begin
      next_st        = st;
      next_st.reload = 1'b0;
      clr            = 3'h0;
      set            = {wd.bite, pl_rst, ext_act};

      // Two-cycle APB access: the answer is prepared in the first access cycle
      // and presented with pready in the second; writes land on that edge.
      if (apb_acc && st.pready) begin
         next_st.pready  = 1'b0;
         next_st.pslverr = 1'b0;
         if (pwrite && !st.pslverr) begin
            unique case (paddr)
               OFF_RELOAD: next_st.reload = 1'b1;
               OFF_STAT: clr = pwdata[2:0];
               default: ;
            endcase
         end
      end else if (apb_acc) begin
         next_st.pready  = 1'b1;
         next_st.pslverr = 1'b0;
         unique case (paddr)
            OFF_RELOAD: next_st.prdata = 32'h0;
            OFF_OPT: next_st.prdata = {23'h0, st.ld == LD_DONE, st.opt};
            OFF_STAT: next_st.prdata = {29'h0, st.cause};
            OFF_CNT: next_st.prdata = {7'h0, wd.count};
            default: begin
               next_st.prdata  = 32'h0;
               next_st.pslverr = 1'b1;
            end
         endcase
      end

      // A cause raised in the same cycle as its clear stays set.
      next_st.cause = (st.cause & ~clr) | set;

      // Until the flash answers, the options keep their all-ones default.
      unique case (st.ld)
         LD_WAIT: begin
            if (flash_ack) begin
               next_st.opt      = flash_data;
               next_st.flash_rd = 1'b0;
               next_st.ld       = LD_DONE;
            end
         end
         LD_DONE: next_st.flash_rd = 1'b0;
      endcase

      unique case (st.pl)
         PL_OK: begin
            if (pl_en && below) begin
               next_st.pl = PL_LOW;
            end
         end
         PL_LOW: begin
            if (!pl_en) begin
               next_st.pl = PL_OK;
            end else if (above && !below) begin
               next_st.pl     = PL_WAIT;
               next_st.pl_tmr = '0;
            end
         end
         PL_WAIT: begin
            // A dip back under the upper threshold restarts the release delay.
            if (!pl_en) begin
               next_st.pl = PL_OK;
            end else if (below || !above) begin
               next_st.pl = PL_LOW;
            end else if (st.pl_tmr == PL_TMR_W'(PL_REL_CYC - 1)) begin
               next_st.pl = PL_OK;
            end else begin
               next_st.pl_tmr = st.pl_tmr + PL_TMR_W'(1);
            end
         end
         default: next_st.pl = PL_OK;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= TOP_RESET;
      end else if (ce) begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset || !ce);

   sequence opt_fetch;
      st.flash_rd && flash_ack;
   endsequence

   sequence supply_good;
      pl_en && above && !below;
   endsequence

   ext_cause_a: assert property (ext_act |=> st.cause[STAT_EXT] ##1 sys_rst)
      else $error("external reset not recorded or not driven");
   pl_assert_a: assert property (pl_en && below && st.pl == PL_OK |=> pl_rst ##1 sys_rst)
      else $error("power-low did not assert reset");
   pl_release_a: assert property ($fell(pl_rst) && pl_en |->
         $past(st.pl) == PL_WAIT && $past(st.pl_tmr) == PL_TMR_W'(PL_REL_CYC - 1))
      else $error("power-low released early");
   pl_wait_a: assert property ((st.pl == PL_WAIT && st.pl_tmr != PL_TMR_W'(PL_REL_CYC - 1))
         and supply_good |=> pl_rst)
      else $error("power-low released without delay");
   pl_disable_a: assert property (st.opt[OPT_PL_DIS] |=> !pl_rst)
      else $error("disabled power-low kept reset");
   wd_reset_a: assert property (wd.bite |=> st.cause[STAT_WD] && sys_rst)
      else $error("watchdog expiry did not reset");
   wd_reload_a: assert property (apb_acc && st.pready && pwrite && paddr == OFF_RELOAD
         && !st.pslverr |=> wd.reload ##1 wd.count == '0)
      else $error("reload write did not restart the watchdog");
   wd_enable_a: assert property (wd.enable == !st.opt[OPT_WD_DIS] &&
         wd.sel == st.opt[3:2])
      else $error("watchdog option decode wrong");
   opt_default_a: assert property (st.ld == LD_WAIT |-> st.opt == OPT_RESET)
      else $error("options not at default before load");
   opt_load_a: assert property (opt_fetch |=> !st.flash_rd && st.ld == LD_DONE &&
         st.opt == $past(flash_data))
      else $error("option byte not taken from flash");
   sys_restart_a: assert property (sys_rst |=> wd.count == '0)
      else $error("watchdog ran during system reset");
   apb_ready_a: assert property (apb_acc && !st.pready |=> st.pready)
      else $error("APB access not answered");
endmodule
`default_nettype wire

// File: dv/wrs_flash_model.sv
// Behavioural option-byte store that answers the supervisor's load request.
`timescale 1ns/1ps
`default_nettype none
module wrs_flash_model #(
   parameter int LAT = 3
) (
   input  wire logic        mclk,
   input  wire logic        flash_rd,
   input  wire logic [14:0] flash_addr,
   input  wire logic [7:0]  opt,
   output logic             flash_ack,
   output logic      [7:0]  flash_data
);
   int cnt = 0;
   initial begin
      flash_ack = 1'b0;
      flash_data = 8'h5a;
   end
   // The data bus is inverted every idle cycle, so a stale byte is never mistaken for a valid one.
   always @(posedge mclk) begin
      if (flash_rd && !flash_ack && cnt == LAT) begin
         flash_ack <= 1'b1;
         flash_data <= (flash_addr === 15'h7fff) ? opt : 8'h00;
         cnt <= 0;
      end else begin
         flash_ack <= 1'b0;
         flash_data <= ~flash_data;
         cnt <= (flash_rd && !flash_ack) ? cnt + 1 : 0;
      end
   end
endmodule
`default_nettype wire

// File: dv/tb_watchdog_reset_supervisor.sv
// Self-checking testbench for the reset supervisor top.
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_reset_supervisor import wrs_pkg::*;;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ext_rst_n = 1'b1;
   logic        vcc_below_low = 1'b0;
   logic        vcc_above_high = 1'b1;
   logic        flash_rd;
   logic [14:0] flash_addr;
   logic        flash_ack;
   logic [7:0]  flash_data;
   logic        sys_rst;
   logic [7:0]  opt = 8'hff;
   logic        rst_seen = 1'b0;
   logic [31:0] rd;
   logic        er;
   int          err_total = 0;
   int          num_checks = 0;
   int          n;

   always #2.5 mclk = ~mclk;
   always @(posedge mclk) if (sys_rst === 1'b1) rst_seen <= 1'b1;

   wrs_top #(.WD_E0(4), .WD_E1(5), .WD_E2(6), .WD_E3(7)) dut_u (
      .mclk(mclk), .reset(reset), .ce(1'b1), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_rst_n(ext_rst_n),
      .vcc_below_low(vcc_below_low), .vcc_above_high(vcc_above_high),
      .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_ack(flash_ack),
      .flash_data(flash_data), .sys_rst(sys_rst));

   wrs_flash_model flash_u (
      .mclk(mclk), .flash_rd(flash_rd), .flash_addr(flash_addr), .opt(opt),
      .flash_ack(flash_ack), .flash_data(flash_data));

   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Entered just after a rising edge; the request stands until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         chk(1'b0, 1'b1, "apb timeout");
         end_of_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps the next call from driving psel twice in one time step.
      @(posedge mclk);
   endtask

   task automatic wait_rst(input logic lvl, input int max);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (sys_rst !== lvl && n < max);
      if (n >= max) begin
         chk(1'b0, 1'b1, "sys_rst wait timeout");
         end_of_test();
      end
   endtask

   task automatic reset_dut(input logic [7:0] ob);
      opt <= ob;
      reset <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(flash_addr, 15'h7fff, "option address");
      chk(sys_rst, 1'b1, "reset output during reset");
      reset <= 1'b0;
      wait_rst(1'b0, 200);
      rst_seen <= 1'b0;
   endtask

   task automatic t_defaults;
      reset_dut(8'hff);
      apb(1'b0, OFF_OPT, 32'h0);
      chk(rd, 32'h1ff, "option byte loaded");
      apb(1'b0, OFF_STAT, 32'h0);
      chk(rd, 32'h0, "cause after reset");
      vcc_below_low <= 1'b1;
      vcc_above_high <= 1'b0;
      repeat (300) @(posedge mclk);
      chk(rst_seen, 1'b0, "disabled watchdog and power-low stay quiet");
      vcc_below_low <= 1'b0;
      vcc_above_high <= 1'b1;
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0, "unmapped read data");
      chk({31'h0, er}, 32'h1, "unmapped read refused");
   endtask

   // Two consecutive periods: the second starts after a watchdog reset.
   task automatic t_intervals;
      int e;
      for (int s = 0; s < 4; s++) begin
         e = (s == 0) ? 4 : s + 4;
         reset_dut({3'b111, 1'b1, s[1:0], 1'b0, 1'b1});
         for (int p = 0; p < 2; p++) begin
            wait_rst(1'b1, 300);
            chk(n >= (1 << e) && n <= (1 << e) + 4, 1'b1, "watchdog interval");
            wait_rst(1'b0, 100);
         end
         apb(1'b0, OFF_STAT, 32'h0);
         chk(rd, 32'h4, "watchdog cause");
      end
   endtask

   task automatic t_reload;
      reset_dut(8'hf1);
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, OFF_RELOAD, (i % 2) ? 32'hffffffff : 32'h0);
         repeat (6) @(posedge mclk);
      end
      chk(rst_seen, 1'b0, "reloaded watchdog never expires");
      apb(1'b1, OFF_RELOAD, 32'h12345678);
      apb(1'b0, OFF_CNT, 32'h0);
      chk(rd <= 32'h4, 1'b1, "count restarts on reload");
   endtask

   task automatic t_ext;
      reset_dut(8'hff);
      ext_rst_n <= 1'b0;
      wait_rst(1'b1, 5);
      ext_rst_n <= 1'b1;
      wait_rst(1'b0, 40);
      chk(n >= 9, 1'b1, "reset stretched after pin release");
      apb(1'b0, OFF_STAT, 32'h0);
      chk(rd, 32'h1, "pin cause");
   endtask

   task automatic t_power;
      reset_dut(8'hef);
      vcc_above_high <= 1'b0;
      vcc_below_low <= 1'b1;
      wait_rst(1'b1, 8);
      vcc_below_low <= 1'b0;
      repeat (600) @(posedge mclk);
      chk(sys_rst, 1'b1, "held until upper threshold");
      vcc_above_high <= 1'b1;
      wait_rst(1'b0, 1000);
      chk(n >= 400 && n <= 420, 1'b1, "power-low release delay");
      apb(1'b0, OFF_STAT, 32'h0);
      chk(rd, 32'h2, "power-low cause");
   endtask

   initial begin
      t_defaults();
      t_intervals();
      t_reload();
      t_ext();
      t_power();
      end_of_test();
   end
endmodule
`default_nettype wire
